// ---- hw/i2c_intr_pkg.sv ----
// Shared constants and types of the interrupt status and mask block.
package i2c_intr_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the register port.
  localparam int ADDR_W = 32;
  localparam int REG_W = 16;
  localparam logic [ADDR_W-1:0] INTR_STATUS_ADDR = 32'h5000132c;
  localparam logic [ADDR_W-1:0] INTR_MASK_ADDR = 32'h50001330;
  localparam logic [REG_W-1:0] INTR_STATUS_RESET = 16'h0000;

  //////////////////////////////////////////////////////////////////////////
  // Flag field positions, shared by status and mask registers.
  localparam int FLAG_W = 12;
  localparam int GEN_CALL_BIT = 11;
  localparam int START_SEEN_BIT = 10;
  localparam int STOP_SEEN_BIT = 9;
  localparam int BUSY_BIT = 8;
  localparam int SEND_DONE_BIT = 7;
  localparam int SEND_ABORT_BIT = 6;
  localparam int READ_REQ_BIT = 5;
  localparam int SEND_EMPTY_BIT = 4;
  localparam int SEND_OVER_BIT = 3;
  localparam int RECV_FULL_BIT = 2;
  localparam int RECV_OVER_BIT = 1;
  localparam int RECV_UNDER_BIT = 0;

  // Mask reset: bits 11 and 7..0 enabled, bits 10..8 masked off.
  localparam logic [FLAG_W-1:0] MASK_RESET = 12'h8ff;

  //////////////////////////////////////////////////////////////////////////
  // FIFO sizing and abort cause width.
  localparam int FIFO_DEPTH = 32;
  localparam int CAUSE_W = 16;

  // Internal enable: running, draining after disable, or off.
  typedef enum logic [1:0] {
    EN_OFF,
    EN_ON,
    EN_DRAIN
  } enable_state_t;

endpackage

// ---- hw/flag_if.sv ----
// Set, clear and state vectors of a bank of sticky flags.
`timescale 1ns/1ns
interface flag_if #(
  parameter int N = 12
);
  logic [N-1:0] set;
  logic [N-1:0] clr;
  logic [N-1:0] q;

  // Controller side drives the events and reads the flags.
  modport ctrl (output set, output clr, input q);
  // Bank side holds the flags.
  modport bank (input set, input clr, output q);
endinterface

// ---- hw/flag_bank.sv ----
// Bank of sticky flags where a set in the clearing cycle wins.
`timescale 1ns/1ns
module flag_bank #(
  parameter int N = 12
) (
  input wire logic ref_clk_i, // System clock.
  input wire logic rst_n_i,   // Synchronous reset, active low.
  flag_if.bank flags          // Set, clear and flag state.
);

  // One flip-flop per flag; the set term is ORed after the clear.
  for (genvar i = 0; i < N; i++) begin : g_flag
    always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
        flags.q[i] <= 1'b0;
      end else begin
        flags.q[i] <= flags.set[i] | (flags.q[i] & ~flags.clr[i]);
      end
    end
  end

endmodule

// ---- hw/i2c_intr_status.sv ----
// Interrupt status, mask and event flag logic of the I2C controller.
`timescale 1ns/1ns
module i2c_intr_status #(
  parameter int DEPTH = i2c_intr_pkg::FIFO_DEPTH,
  parameter int LEVEL_W = $clog2(i2c_intr_pkg::FIFO_DEPTH + 1)
) (
  input wire logic ref_clk_i, // System clock, 100 MHz.
  input wire logic rst_n_i,   // Synchronous reset, active low.
  // Register port.
  input wire logic [i2c_intr_pkg::ADDR_W-1:0] reg_addr_i, // Byte address.
  input wire logic reg_wr_i,  // Write strobe.
  input wire logic reg_rd_i,  // Read strobe.
  input wire logic [i2c_intr_pkg::REG_W-1:0] reg_wdata_i, // Write data.
  output logic [i2c_intr_pkg::REG_W-1:0] reg_rdata_o, // Read data.
  // Controller enable and machine activity.
  input wire logic enable_i,    // Enable bit 0 of the enable register.
  input wire logic sm_active_i, // Master or slave machine not idle.
  // Bus events, one-cycle pulses.
  input wire logic start_seen_i,  // START or repeated START seen.
  input wire logic stop_seen_i,   // STOP seen.
  input wire logic bus_active_i,  // Controller activity.
  input wire logic slv_tx_nack_i, // Slave transmit byte not acknowledged.
  input wire logic tx_abort_i,    // Queued transmit could not complete.
  input wire logic [i2c_intr_pkg::CAUSE_W-1:0] abort_cause_i, // Cause.
  input wire logic rd_req_i,      // Addressed as slave for read.
  input wire logic gen_call_ack_i, // General call received and acked.
  input wire logic rx_byte_i,     // Byte received from the bus.
  // FIFO levels and thresholds.
  input wire logic [LEVEL_W-1:0] tx_level_i,  // Send FIFO level.
  input wire logic [LEVEL_W-1:0] rx_level_i,  // Receive FIFO level.
  input wire logic [LEVEL_W-1:0] send_threshold_i, // Send threshold.
  input wire logic [LEVEL_W-1:0] receive_threshold_i, // Receive threshold.
  // Data command register accesses.
  input wire logic data_cmd_wr_i, // Software wrote data command.
  input wire logic data_cmd_rd_i, // Software read data command.
  // Clear register reads, one-cycle pulses.
  input wire logic combined_clear_rd_i, // Combined clear read.
  input wire logic busy_clear_rd_i,     // Busy clear read.
  input wire logic abort_clear_rd_i,    // Abort clear read.
  input wire logic read_request_clear_rd_i, // Read-request clear read.
  input wire logic gen_call_clear_rd_i, // General-call clear read.
  input wire logic send_done_clear_rd_i, // Send-done clear read.
  input wire logic start_clear_rd_i,    // Start clear read.
  input wire logic stop_clear_rd_i,     // Stop clear read.
  input wire logic send_over_clear_rd_i, // Send overflow clear read.
  input wire logic recv_over_clear_rd_i, // Receive overflow clear read.
  input wire logic recv_under_clear_rd_i, // Receive underflow clear read.
  // Results.
  output logic intr_o,             // Combined interrupt, active high.
  output logic [i2c_intr_pkg::FLAG_W-1:0] intr_status_o, // Masked flags.
  output logic [i2c_intr_pkg::CAUSE_W-1:0] abort_cause_o, // Abort cause.
  output logic tx_flush_o,         // Hold send FIFO flushed.
  output logic rx_flush_o,         // Hold receive FIFO flushed.
  output logic scl_hold_o,         // Stretch SCL low.
  output logic rx_store_o,         // Push received byte.
  output logic rx_discard_o,       // Drop received byte, still acked.
  output logic internal_enable_o   // Internal enable.
);
  import i2c_intr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  localparam logic [LEVEL_W-1:0] FULL_LEVEL = LEVEL_W'(DEPTH);
  localparam logic [LEVEL_W-1:0] EMPTY_LEVEL = '0;

  enable_state_t en_state;
  enable_state_t next_en_state;
  logic [FLAG_W-1:0] intr_mask;
  logic [FLAG_W-1:0] next_status;
  logic [REG_W-1:0] next_rdata;
  logic [CAUSE_W-1:0] next_cause;

  flag_if #(.N(FLAG_W)) flags ();

  ////////////////////////////////////////////////////////////////////////////
  // Decoding of register port and controller conditions.
  wire logic sel_status = (reg_addr_i == INTR_STATUS_ADDR);
  wire logic sel_mask = (reg_addr_i == INTR_MASK_ADDR);
  wire logic mask_wr = reg_wr_i & sel_mask;
  wire logic disabled = ~enable_i;
  wire logic int_en_low = (en_state == EN_OFF);
  wire logic tx_full = (tx_level_i == FULL_LEVEL);
  wire logic rx_full = (rx_level_i == FULL_LEVEL);
  wire logic rx_empty = (rx_level_i == EMPTY_LEVEL);

  ////////////////////////////////////////////////////////////////////////////
  // Internal enable follows the enable bit up at once, but after a disable
  // it stays high until the master and slave machines have gone idle.
  always_comb begin
    next_en_state = en_state;
    unique case (en_state)
      EN_OFF: begin
        if (enable_i) begin
          next_en_state = EN_ON;
        end
      end
      EN_ON: begin
        if (!enable_i) begin
          next_en_state = sm_active_i ? EN_DRAIN : EN_OFF;
        end
      end
      EN_DRAIN: begin
        if (enable_i) begin
          next_en_state = EN_ON;
        end else if (!sm_active_i) begin
          next_en_state = EN_OFF;
        end
      end
    endcase
  end

  // Enable state register.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      en_state <= EN_OFF;
      internal_enable_o <= 1'b0;
    end else begin
      en_state <= next_en_state;
      internal_enable_o <= (next_en_state != EN_OFF);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Set terms. A set wins over a clear in the same cycle.
  assign flags.set[START_SEEN_BIT] = start_seen_i;
  assign flags.set[STOP_SEEN_BIT] = stop_seen_i;
  assign flags.set[BUSY_BIT] = bus_active_i;
  assign flags.set[SEND_DONE_BIT] = slv_tx_nack_i;
  assign flags.set[SEND_ABORT_BIT] = tx_abort_i;
  assign flags.set[READ_REQ_BIT] = rd_req_i;
  assign flags.set[GEN_CALL_BIT] = gen_call_ack_i;
  assign flags.set[SEND_OVER_BIT] = data_cmd_wr_i & tx_full;
  assign flags.set[RECV_OVER_BIT] = rx_byte_i & rx_full;
  assign flags.set[RECV_UNDER_BIT] = data_cmd_rd_i & rx_empty;

  // Level flags: the send FIFO looks empty while disabled, so send-empty
  // then tracks whether the machines are still active.
  assign flags.set[SEND_EMPTY_BIT] = enable_i ?
    (tx_level_i <= send_threshold_i) : sm_active_i;
  // Receive-full drops the moment the enable bit is written to 0.
  assign flags.set[RECV_FULL_BIT] = enable_i &
    (rx_level_i >= receive_threshold_i);

  ////////////////////////////////////////////////////////////////////////////
  // Clear terms.
  assign flags.clr[START_SEEN_BIT] = start_clear_rd_i | combined_clear_rd_i;
  assign flags.clr[STOP_SEEN_BIT] = stop_clear_rd_i | combined_clear_rd_i;
  // Busy holds through idle; only these three actions drop it.
  assign flags.clr[BUSY_BIT] = disabled | busy_clear_rd_i |
    combined_clear_rd_i;
  assign flags.clr[SEND_DONE_BIT] = send_done_clear_rd_i |
    combined_clear_rd_i;
  assign flags.clr[SEND_ABORT_BIT] = abort_clear_rd_i |
    combined_clear_rd_i;
  assign flags.clr[READ_REQ_BIT] = read_request_clear_rd_i |
    combined_clear_rd_i;
  assign flags.clr[GEN_CALL_BIT] = disabled | gen_call_clear_rd_i |
    combined_clear_rd_i;
  // Overflow and underflow hold their level until internal enable is low or their own or the combined clear is read.
  assign flags.clr[SEND_OVER_BIT] = int_en_low | send_over_clear_rd_i |
    combined_clear_rd_i;
  assign flags.clr[RECV_OVER_BIT] = int_en_low | recv_over_clear_rd_i |
    combined_clear_rd_i;
  assign flags.clr[RECV_UNDER_BIT] = int_en_low | recv_under_clear_rd_i |
    combined_clear_rd_i;
  // Level flags follow their condition with no memory.
  assign flags.clr[SEND_EMPTY_BIT] = 1'b1;
  assign flags.clr[RECV_FULL_BIT] = 1'b1;

  // Raw event flags.
  flag_bank #(
    .N(FLAG_W)
  ) u_flags (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .flags(flags)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mask register, one enable bit per flag at the same position.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      intr_mask <= MASK_RESET;
    end else if (mask_wr) begin
      intr_mask <= reg_wdata_i[FLAG_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Masked status and combined interrupt line.
  assign next_status = flags.q & intr_mask;

  // Status and interrupt registers.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      intr_status_o <= INTR_STATUS_RESET[FLAG_W-1:0];
      intr_o <= 1'b0;
    end else begin
      intr_status_o <= next_status;
      intr_o <= |next_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data: masked status or mask, reserved bits and other addresses 0.
  always_comb begin
    next_rdata = reg_rdata_o;
    if (reg_rd_i) begin
      if (sel_status) begin
        next_rdata = {{(REG_W-FLAG_W){1'b0}}, next_status};
      end else if (sel_mask) begin
        next_rdata = {{(REG_W-FLAG_W){1'b0}}, intr_mask};
      end else begin
        next_rdata = '0;
      end
    end
  end

  // Read data register holds until the next read.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Abort cause: captured with the abort, zeroed when the abort is cleared.
  always_comb begin
    next_cause = abort_cause_o;
    if (tx_abort_i) begin
      next_cause = abort_cause_i;
    end else if (flags.clr[SEND_ABORT_BIT]) begin
      next_cause = '0;
    end
  end

  // Abort cause register.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      abort_cause_o <= '0;
    end else begin
      abort_cause_o <= next_cause;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // FIFO and bus controls. The send flush and clock hold use the flag's
  // next value so that they line up with the flag itself.
  wire logic next_abort = flags.set[SEND_ABORT_BIT] |
    (flags.q[SEND_ABORT_BIT] & ~flags.clr[SEND_ABORT_BIT]);
  wire logic next_read_req = flags.set[READ_REQ_BIT] |
    (flags.q[READ_REQ_BIT] & ~flags.clr[READ_REQ_BIT]);
  wire logic rx_room = rx_byte_i & ~rx_full;

  // Control registers.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tx_flush_o <= 1'b1;
      rx_flush_o <= 1'b1;
      scl_hold_o <= 1'b0;
      rx_store_o <= 1'b0;
      rx_discard_o <= 1'b0;
    end else begin
      tx_flush_o <= next_abort | disabled;
      rx_flush_o <= disabled;
      scl_hold_o <= next_read_req;
      rx_store_o <= rx_room;
      rx_discard_o <= rx_byte_i & rx_full;
    end
  end

endmodule

// ---- testbench/remote_model.sv ----
// Model of the remote bus parties that cause bus events.
`timescale 1ns/1ns
module remote_model (
  input wire logic ref_clk_i, // System clock.
  output logic [7:0] ev_o     // One-cycle event pulses.
);
  // Events in bit order: start, stop, activity, nack, abort, read
  // request, general call, received byte.
  initial ev_o = 8'h00;

  // Raise one event for exactly one cycle, launched from a falling edge.
  task automatic fire(input int idx);
    @(negedge ref_clk_i);
    ev_o = 8'h01 << idx;
    @(negedge ref_clk_i);
    ev_o = 8'h00;
  endtask
endmodule

// ---- testbench/intr_checker_assertions.sv ----
// Port-level checks of the interrupt status and mask block.
`timescale 1ns/1ns
module intr_checker #(
  parameter int DEPTH = 32,
  parameter int LEVEL_W = 6
) (
  input wire logic ref_clk_i, // System clock.
  input wire logic rst_n_i, // Reset, active low.
  input wire logic enable_i, // Enable bit.
  input wire logic sm_active_i, // Machines busy.
  input wire logic tx_abort_i, // Abort event.
  input wire logic [15:0] abort_cause_i, // Cause in.
  input wire logic rd_req_i, // Read request event.
  input wire logic rx_byte_i, // Byte received.
  input wire logic [LEVEL_W-1:0] rx_level_i, // Receive level.
  input wire logic read_request_clear_rd_i, // Request clear read.
  input wire logic intr_o, // Interrupt.
  input wire logic [11:0] intr_status_o, // Masked status.
  input wire logic [15:0] abort_cause_o, // Cause out.
  input wire logic tx_flush_o, // Send flush.
  input wire logic rx_flush_o, // Receive flush.
  input wire logic scl_hold_o, // Clock stretch.
  input wire logic rx_store_o, // Byte stored.
  input wire logic rx_discard_o, // Byte dropped.
  input wire logic internal_enable_o // Internal enable.
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  //////////////////////////////////////////////////////////////////////////
  // Checks tie the flush, clock hold, store, drop, cause and enable outputs to their causes with the exact delay.
  a_hold_on_request: assert property (rd_req_i |=> scl_hold_o)
    else $error("Clock not stretched after read request.");
  a_request_release: assert property
    (read_request_clear_rd_i && !rd_req_i |=> !scl_hold_o)
    else $error("Clock still stretched after request clear.");
  a_intr_is_or: assert property (intr_o == |intr_status_o)
    else $error("Interrupt differs from OR of status.");
  a_abort_cause: assert property
    (tx_abort_i |=> tx_flush_o && abort_cause_o == $past(abort_cause_i))
    else $error("Abort cause or send flush wrong.");
  a_drop_when_full: assert property
    (rx_byte_i && rx_level_i == DEPTH |=> rx_discard_o && !rx_store_o)
    else $error("Byte into full receive buffer not dropped.");
  a_store_with_room: assert property
    (rx_byte_i && rx_level_i < DEPTH |=> rx_store_o && !rx_discard_o)
    else $error("Byte with room not stored.");
  a_rx_flush_on: assert property (!enable_i |=> rx_flush_o)
    else $error("Receive buffer not flushed when disabled.");
  a_rx_flush_off: assert property (enable_i |=> !rx_flush_o)
    else $error("Receive buffer flushed while enabled.");
  a_enable_follow: assert property (enable_i |=> internal_enable_o)
    else $error("Internal enable did not follow enable.");
  a_enable_drop: assert property
    (!enable_i && !sm_active_i |=> !internal_enable_o)
    else $error("Internal enable stayed up while idle.");

  // Main scenarios.
  c_request: cover property (rd_req_i ##1 scl_hold_o);
  c_abort: cover property (tx_abort_i ##1 tx_flush_o);
  c_drop: cover property (rx_byte_i && rx_level_i == DEPTH);
endmodule

bind i2c_intr_status intr_checker #(.DEPTH(DEPTH), .LEVEL_W(LEVEL_W)) u_chk (
  .ref_clk_i, .rst_n_i, .enable_i, .sm_active_i, .tx_abort_i,
  .abort_cause_i, .rd_req_i, .rx_byte_i, .rx_level_i,
  .read_request_clear_rd_i, .intr_o, .intr_status_o, .abort_cause_o,
  .tx_flush_o, .rx_flush_o, .scl_hold_o, .rx_store_o, .rx_discard_o,
  .internal_enable_o
);

// ---- testbench/testbench.sv ----
// Self-checking bench for the interrupt status and mask block.
`timescale 1ns/1ns
module testbench;
  import i2c_intr_pkg::*;
  // Inputs start at safe values: enabled thresholds keep level flags low.
  logic ref_clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [31:0] reg_addr_i = 0;
  logic [15:0] reg_wdata_i = 0, abort_cause_i = 0;
  logic enable_i = 0, sm_active_i = 0, data_cmd_wr_i = 0, data_cmd_rd_i = 0;
  logic [5:0] tx_level_i = 10, rx_level_i = 0;
  logic [5:0] send_threshold_i = 2, receive_threshold_i = 1;
  logic combined_clear_rd_i = 0, busy_clear_rd_i = 0, abort_clear_rd_i = 0;
  logic read_request_clear_rd_i = 0, gen_call_clear_rd_i = 0;
  logic send_done_clear_rd_i = 0, start_clear_rd_i = 0, stop_clear_rd_i = 0;
  logic send_over_clear_rd_i = 0, recv_over_clear_rd_i = 0;
  logic recv_under_clear_rd_i = 0;
  wire logic [7:0] ev;
  wire logic start_seen_i, stop_seen_i, bus_active_i, slv_tx_nack_i;
  wire logic tx_abort_i, rd_req_i, gen_call_ack_i, rx_byte_i;
  logic [15:0] reg_rdata_o, abort_cause_o;
  logic [11:0] intr_status_o;
  logic intr_o, tx_flush_o, rx_flush_o, scl_hold_o, rx_store_o;
  logic rx_discard_o, internal_enable_o;
  int miscompares = 0, n_compared = 0, cycles = 0;

  assign {rx_byte_i, gen_call_ack_i, rd_req_i, tx_abort_i, slv_tx_nack_i,
    bus_active_i, stop_seen_i, start_seen_i} = ev;

  remote_model remote (.ref_clk_i, .ev_o(ev));
  i2c_intr_status dut (.ref_clk_i, .rst_n_i, .reg_addr_i, .reg_wr_i,
    .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .enable_i, .sm_active_i,
    .start_seen_i, .stop_seen_i, .bus_active_i, .slv_tx_nack_i, .tx_abort_i,
    .abort_cause_i, .rd_req_i, .gen_call_ack_i, .rx_byte_i, .tx_level_i,
    .rx_level_i, .send_threshold_i, .receive_threshold_i, .data_cmd_wr_i,
    .data_cmd_rd_i, .combined_clear_rd_i, .busy_clear_rd_i,
    .abort_clear_rd_i, .read_request_clear_rd_i, .gen_call_clear_rd_i,
    .send_done_clear_rd_i, .start_clear_rd_i, .stop_clear_rd_i,
    .send_over_clear_rd_i, .recv_over_clear_rd_i, .recv_under_clear_rd_i,
    .intr_o, .intr_status_o, .abort_cause_o, .tx_flush_o, .rx_flush_o,
    .scl_hold_o, .rx_store_o, .rx_discard_o, .internal_enable_o);

  //////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; a run needs well under a thousand cycles.
  always #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Shared helpers; all drive from falling edges.
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic chk(input string what, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      $display("FAIL %s expected %h seen %h", what, exp, seen);
      miscompares++;
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic reg_wr(input logic [31:0] a, input logic [15:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    pulse(reg_wr_i);
  endtask
  task automatic reg_rd(input logic [31:0] a, input logic [15:0] exp);
    reg_addr_i = a;
    pulse(reg_rd_i);
    cyc(1);
    chk("register read", reg_rdata_o, exp);
  endtask
  task automatic st(input string what, input logic [15:0] exp);
    chk(what, {4'h0, intr_status_o}, exp);
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_regs();
    reg_rd(INTR_MASK_ADDR, 16'h08ff);
    reg_rd(INTR_STATUS_ADDR, INTR_STATUS_RESET);
    reg_wr(INTR_STATUS_ADDR, 16'hffff);
    reg_rd(INTR_MASK_ADDR, 16'h08ff);
    reg_rd(32'h50001334, 16'h0000);
    reg_wr(INTR_MASK_ADDR, 16'hffff);
    reg_rd(INTR_MASK_ADDR, 16'h0fff);
    $display("registers test done");
  endtask
  task automatic t_events();
    int pos[7] = '{10, 9, 8, 7, 6, 5, 11};
    for (int i = 0; i < 7; i++) begin
      remote.fire(i);
      cyc(2);
      st("event status", 16'h1 << pos[i]);
      chk("event interrupt", {15'h0, intr_o}, 16'h1);
      case (i)
        0: pulse(start_clear_rd_i);
        1: pulse(stop_clear_rd_i);
        3: pulse(send_done_clear_rd_i);
        6: pulse(gen_call_clear_rd_i);
        default: pulse(combined_clear_rd_i);
      endcase
      cyc(2);
      st("event cleared", 16'h0);
    end
    $display("events test done");
  endtask
  task automatic t_busy();
    remote.fire(2);
    cyc(6);
    st("activity kept", 16'h0100);
    pulse(busy_clear_rd_i);
    cyc(2);
    st("activity cleared", 16'h0);
    remote.fire(2);
    enable_i = 0;
    cyc(3);
    st("activity off", 16'h0);
    enable_i = 1;
    cyc(2);
    $display("activity test done");
  endtask
  task automatic t_rdreq_abort();
    remote.fire(5);
    cyc(4);
    chk("clock held", {15'h0, scl_hold_o}, 16'h1);
    pulse(data_cmd_wr_i);
    chk("held after reply", {15'h0, scl_hold_o}, 16'h1);
    pulse(read_request_clear_rd_i);
    chk("clock released", {15'h0, scl_hold_o}, 16'h0);
    abort_cause_i = 16'h0a5c;
    remote.fire(4);
    abort_cause_i = 0;
    cyc(5);
    chk("abort cause", abort_cause_o, 16'h0a5c);
    chk("flush kept", {15'h0, tx_flush_o}, 16'h1);
    pulse(abort_clear_rd_i);
    cyc(1);
    chk("flush released", {15'h0, tx_flush_o}, 16'h0);
    $display("request and abort test done");
  endtask
  task automatic t_levels();
    // A byte with room is pushed, not dropped.
    remote.fire(7);
    chk("byte stored", {15'h0, rx_store_o}, 16'h1);
    chk("byte kept", {15'h0, rx_discard_o}, 16'h0);
    tx_level_i = 2;
    rx_level_i = 1;
    cyc(3);
    st("at thresholds", 16'h0014);
    tx_level_i = 3;
    rx_level_i = 0;
    cyc(3);
    st("past thresholds", 16'h0);
    // Other thresholds move the comparison points with them.
    send_threshold_i = 5;
    receive_threshold_i = 4;
    tx_level_i = 5;
    rx_level_i = 4;
    cyc(3);
    st("new thresholds", 16'h0014);
    tx_level_i = 6;
    rx_level_i = 3;
    cyc(3);
    st("past new thresholds", 16'h0);
    send_threshold_i = 2;
    receive_threshold_i = 1;
    rx_level_i = 32;
    sm_active_i = 1;
    enable_i = 0;
    cyc(3);
    st("off while active", 16'h0010);
    chk("receive flushed", {15'h0, rx_flush_o}, 16'h1);
    chk("enable draining", {15'h0, internal_enable_o}, 16'h1);
    sm_active_i = 0;
    cyc(3);
    st("off and idle", 16'h0);
    chk("enable dropped", {15'h0, internal_enable_o}, 16'h0);
    enable_i = 1;
    rx_level_i = 0;
    tx_level_i = 10;
    cyc(2);
    $display("levels test done");
  endtask
  task automatic t_over(input bit own);
    tx_level_i = 32;
    pulse(data_cmd_wr_i);
    tx_level_i = 10;
    rx_level_i = 32;
    remote.fire(7);
    chk("byte dropped", {15'h0, rx_discard_o}, 16'h1);
    rx_level_i = 0;
    pulse(data_cmd_rd_i);
    cyc(2);
    st("overflow flags", 16'h000b);
    if (own) begin
      pulse(send_over_clear_rd_i);
      pulse(recv_over_clear_rd_i);
      pulse(recv_under_clear_rd_i);
    end else begin
      sm_active_i = 1;
      enable_i = 0;
      cyc(4);
      st("held while active", 16'h001b);
      sm_active_i = 0;
    end
    cyc(4);
    st("overflow cleared", 16'h0);
    enable_i = 1;
    cyc(2);
    $display("overflow test done");
  endtask
  task automatic t_mask();
    reg_wr(INTR_MASK_ADDR, 16'h0000);
    remote.fire(5);
    cyc(2);
    st("masked status", 16'h0);
    chk("masked interrupt", {15'h0, intr_o}, 16'h0);
    reg_wr(INTR_MASK_ADDR, 16'h0020);
    cyc(2);
    chk("unmasked", {15'h0, intr_o}, 16'h1);
    reg_rd(INTR_STATUS_ADDR, 16'h0020);
    pulse(read_request_clear_rd_i);
    $display("mask test done");
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Verdict and main sequence.
  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    cyc(5);
    rst_n_i = 1;
    enable_i = 1;
    cyc(2);
    t_regs();
    t_events();
    t_busy();
    t_rdreq_abort();
    t_levels();
    t_over(0);
    t_over(1);
    t_mask();
    wrap_up();
  end
endmodule
